// file: common/rtcr_map.svh
// Purpose: offsets, field positions, reset values and timing of the
//          clock control and status registers
// Assumes: byte-wide register port, 7-bit register address
// Notes:   definitions only
`ifndef RTCR_MAP_SVH
`define RTCR_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define RTCR_OFS_RATE   7'h0A
`define RTCR_OFS_MODE   7'h0B
`define RTCR_OFS_FLAG   7'h0C
`define RTCR_OFS_SUPPLY 7'h0D
`define RTCR_OFS_XFLAG  7'h4A
`define RTCR_OFS_XEN    7'h4B

// ****************************************
// field positions
// ****************************************
`define RTCR_B_SET  7
`define RTCR_B_PIE  6
`define RTCR_B_AIE  5
`define RTCR_B_UIE  4
`define RTCR_B_SQUARE_OUT_ENABLE 3
`define RTCR_B_DM   2
`define RTCR_B_H24  1
`define RTCR_B_DSE  0

// ****************************************
// reset values
// ****************************************
`define RTCR_RST_OSC  3'h0
`define RTCR_RST_RATE 4'h0
`define RTCR_RST_MODE 8'h08
`define RTCR_RST_XEN  4'h0

// ****************************************
// timing
// ****************************************
`define RTCR_CLK_HZ      40000000
`define RTCR_XTAL_HZ     32768
`define RTCR_UPD_TK      15'h3FFF
`define RTCR_UIP_LEAD_US 244
`define RTCR_UIP_LEAD_TK \
  ((`RTCR_UIP_LEAD_US * `RTCR_XTAL_HZ + 999999) / 1000000)

`endif

// file: common/rtcr_pkg.sv
// Purpose: types shared by the clock control block and its bench
// Assumes: nothing
// Notes:   constants live in rtcr_map.svh
package rtcr_pkg;

  typedef enum logic [1:0] {
    RTCR_OSC_OFF,
    RTCR_OSC_RUN,
    RTCR_OSC_HOLD
  } rtcr_osc_t;

  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcr_hms_t;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [2:0] dow;
  } rtcr_cal_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rtcr_bus_t;

endpackage : rtcr_pkg

// file: design/rtcr_ctrl.sv
// Purpose: control and status registers of the clock, divider chain,
//          update timing, square wave and interrupt combining
// Assumes: counters outside advance the user copy on xfer_o
// Notes:   one clock; crystal rate made by a phase accumulator
//
// What this block does
// - update-pending low guarantees no transfer for at least 244 us
// - update-pending read-only; writing freeze 1 blocks transfer, clears it
// - oscillator bits 01X run, 11X hold chain in reset, else stop
// - first update comes 500 ms after run pattern is written
// - lowest oscillator bit selects bank 0 or bank 1
// - rate selector picks one of 13 divider taps or none
// - rate codes map to the tabled periods, doubling from code 3
// - fast enable puts 32.768 kHz on the pin; periodic rate unchanged
// - freeze low lets counts advance each second; logic never alters it
// - periodic flag set on every rising tap edge regardless of its enable
// - alarm flag set each matching second; 11XXXXXX matches anything
// - rising freeze bit clears the update-ended enable
// - both square enables low hold pin low; square enable resets to 1
// - data-format bit selects binary or BCD, untouched by logic
// - hour-format bit selects 24 or 12 hour, untouched by logic
// - daylight saving jumps forward in April, back in October
// - daylight saving Sunday tests happen at midnight
// - combined flag is OR of six flag-enable pairs; drives pin low
// - reading the flag register clears periodic, alarm, update flags
// - update-ended flag set after every update cycle
// - low flag bits and low supply bits read zero, ignore writes
// - supply-valid bit is high when either supply is good, read-only
// - the four control registers answer in both banks at all times
// - flags set during a flag read are held until the read ends
// - extended flags clear only by writing zero, never by reading
`timescale 1ns/100ps
`default_nettype none
`include "rtcr_map.svh"

module rtcr_ctrl #(
  parameter int CLK_HZ = `RTCR_CLK_HZ
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  input  wire rtcr_pkg::rtcr_bus_t bus_i,
  output logic [7:0]               bus_rdata_o,
  input  wire rtcr_pkg::rtcr_hms_t time_i,
  input  wire rtcr_pkg::rtcr_hms_t alarm_i,
  input  wire rtcr_pkg::rtcr_cal_t cal_i,
  input  wire logic [2:0]          ext_ev_i,
  input  wire logic                bat_ok_i,
  input  wire logic                aux_ok_i,
  output logic                     xfer_o,
  output logic                     bank_sel_o,
  output logic                     binary_fmt_o,
  output logic                     hour24_o,
  output logic                     dst_fwd_o,
  output logic                     dst_back_o,
  output logic                     square_wave_out_o,
  output logic                     irq_o,
  output logic                     irq_oen_o
);

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [26:0] NCO_MOD  = 27'(CLK_HZ);
  localparam logic [26:0] NCO_STEP = 27'(2 * `RTCR_XTAL_HZ);
  localparam logic [14:0] UIP_PT   =
    15'(`RTCR_UPD_TK - `RTCR_UIP_LEAD_TK);

  logic [2:0]  osc_ctrl_r;
  logic [3:0]  rate_sel_r;
  logic [7:0]  mode_r;
  logic [3:0]  xen_r;
  logic        uip_r;
  logic [25:0] nco_r;
  logic [26:0] nco_sum;
  logic [26:0] nco_dif;
  logic        ph_r;
  logic [14:0] div_r;
  logic        tap_q;
  logic        xfer_r;
  logic        chk_r;
  logic [2:0]  cflag_r;
  logic [2:0]  cpend_r;
  logic [2:0]  xflag_r;
  logic        c_rd_q;
  logic        rd_q;
  logic [7:0]  rdata_r;
  logic        sq_r;
  logic        fwd_arm_r;
  logic        back_arm_r;
  logic        dst_fwd_r;
  logic        dst_back_r;
  logic [4:0]  tap_sel;
  logic [7:0]  rd_mux;
  rtcr_pkg::rtcr_osc_t osc;
  logic        run;
  logic        tick;
  logic        upd;
  logic        tap_lvl;
  logic        tap_rise;
  logic        wr_a;
  logic        wr_b;
  logic        xwr;
  logic        c_rd;
  logic        c_end;
  logic        al_hit;
  logic [2:0]  cev;
  logic [2:0]  cen;
  logic        combined_irq_flag;
  logic        fast;
  logic [7:0]  v59;
  logic [7:0]  v12;

  // ****************************************
  // helpers
  // ****************************************
  // code to tap mapping
  function automatic logic [4:0] rtcr_tap_f(input logic [3:0] c);
    case (c)
      4'h0:    return 5'h00;
      4'h1:    return 5'h16;
      4'h2:    return 5'h17;
      default: return {1'b1, c - 4'h2};
    endcase
  endfunction : rtcr_tap_f

  // alarm byte match with don't care
  function automatic logic rtcr_hit_f(input logic [7:0] t,
                                      input logic [7:0] a);
    return (a[7:6] == 2'b11) || (a == t);
  endfunction : rtcr_hit_f

  // ****************************************
  // decode
  // ****************************************
  // oscillator pattern decode
  always_comb begin
    case (osc_ctrl_r[2:1])
      2'b01:   osc = rtcr_pkg::RTCR_OSC_RUN;
      2'b11:   osc = rtcr_pkg::RTCR_OSC_HOLD;
      default: osc = rtcr_pkg::RTCR_OSC_OFF;
    endcase
  end

  // control registers decode in either bank
  assign run   = (osc == rtcr_pkg::RTCR_OSC_RUN);
  assign wr_a  = bus_i.wr && (bus_i.addr == `RTCR_OFS_RATE);
  assign wr_b  = bus_i.wr && (bus_i.addr == `RTCR_OFS_MODE);
  assign xwr   = bus_i.wr && (bus_i.addr == `RTCR_OFS_XFLAG) && bank_sel_o;
  assign c_rd  = bus_i.rd && (bus_i.addr == `RTCR_OFS_FLAG);
  assign c_end = c_rd_q && !c_rd;
  assign fast  = xen_r[0];
  assign bank_sel_o = osc_ctrl_r[0];
  // format bit passed out as written
  assign binary_fmt_o = mode_r[`RTCR_B_DM];
  // hour format passed out as written
  assign hour24_o = mode_r[`RTCR_B_H24];

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_ctrl_r <= `RTCR_RST_OSC;
      rate_sel_r <= `RTCR_RST_RATE;
    end else if (wr_a) begin
      osc_ctrl_r <= bus_i.wdata[6:4];
      rate_sel_r <= bus_i.wdata[3:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r <= `RTCR_RST_MODE;
    end else if (wr_b) begin
      mode_r <= bus_i.wdata;
      if (bus_i.wdata[`RTCR_B_SET] && !mode_r[`RTCR_B_SET]) begin
        mode_r[`RTCR_B_UIE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xen_r <= `RTCR_RST_XEN;
    end else if (bus_i.wr && bank_sel_o &&
                 (bus_i.addr == `RTCR_OFS_XEN)) begin
      xen_r <= bus_i.wdata[3:0];
    end
  end

  // ****************************************
  // divider chain
  // ****************************************
  assign nco_sum = {1'b0, nco_r} + NCO_STEP;
  assign nco_dif = nco_sum - NCO_MOD;
  assign tick    = run && (nco_sum >= NCO_MOD) && ph_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nco_r <= 26'h0000000;
      ph_r  <= 1'b0;
      div_r <= 15'h0000;
    end else if (!run) begin
      nco_r <= 26'h0000000;
      ph_r  <= 1'b0;
      div_r <= 15'h0000;
    end else if (nco_sum >= NCO_MOD) begin
      nco_r <= nco_dif[25:0];
      ph_r  <= !ph_r;
      if (ph_r) begin
        div_r <= div_r + 15'h0001;
      end
    end else begin
      nco_r <= nco_sum[25:0];
    end
  end

  // one tap shared by pin and flag
  assign tap_sel  = rtcr_tap_f(rate_sel_r);
  assign tap_lvl  = tap_sel[4] && div_r[tap_sel[3:0]];
  assign tap_rise = tap_lvl && !tap_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap_lvl;
    end
  end

  // ****************************************
  // update cycle
  // ****************************************
  // half-second point of a fresh chain
  assign upd = tick && (div_r == `RTCR_UPD_TK);

  // pending raised a full lead before transfer
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uip_r <= 1'b0;
    end else if (wr_b && bus_i.wdata[`RTCR_B_SET]) begin
      // freeze write drops pending at once
      uip_r <= 1'b0;
    end else if (tick && (div_r == UIP_PT) && !mode_r[`RTCR_B_SET]) begin
      uip_r <= 1'b1;
    end else if (upd || !run) begin
      uip_r <= 1'b0;
    end
  end

  // transfer once a second unless frozen
  // needing pending high too keeps the lead even if freeze drops late
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xfer_r <= 1'b0;
      chk_r  <= 1'b0;
    end else begin
      xfer_r <= upd && uip_r && !mode_r[`RTCR_B_SET];
      chk_r  <= xfer_r;
    end
  end
  assign xfer_o = xfer_r;

  // ****************************************
  // alarm and daylight saving
  // ****************************************
  // compare fresh user copy after transfer
  assign al_hit = chk_r && rtcr_hit_f(time_i.hour, alarm_i.hour) &&
                  rtcr_hit_f(time_i.min, alarm_i.min) &&
                  rtcr_hit_f(time_i.sec, alarm_i.sec);

  assign v59 = mode_r[`RTCR_B_DM] ? 8'h3B : 8'h59;
  assign v12 = mode_r[`RTCR_B_H24] ? 8'h00 :
               (mode_r[`RTCR_B_DM] ? 8'h0C : 8'h12);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fwd_arm_r  <= 1'b0;
      back_arm_r <= 1'b0;
      dst_fwd_r  <= 1'b0;
      dst_back_r <= 1'b0;
    end else begin
      dst_fwd_r  <= 1'b0;
      dst_back_r <= 1'b0;
      if (chk_r && time_i.hour == v12 && time_i.min == 8'h00 &&
          time_i.sec == 8'h00) begin
        fwd_arm_r  <= mode_r[`RTCR_B_DSE] && cal_i.dow == 3'h1 &&
                      cal_i.month == 8'h04 && cal_i.date <= 8'h07;
        back_arm_r <= mode_r[`RTCR_B_DSE] && cal_i.dow == 3'h1 &&
                      cal_i.month == (mode_r[`RTCR_B_DM] ? 8'h0A : 8'h10) &&
                      cal_i.date >= (mode_r[`RTCR_B_DM] ? 8'h19 : 8'h25);
      end else if (chk_r && time_i.hour == 8'h01 &&
                   time_i.min == v59 && time_i.sec == v59) begin
        // jump on next advance, back only on first arrival
        dst_fwd_r  <= fwd_arm_r && mode_r[`RTCR_B_DSE];
        dst_back_r <= back_arm_r && mode_r[`RTCR_B_DSE];
        fwd_arm_r  <= 1'b0;
        back_arm_r <= 1'b0;
      end
    end
  end
  assign dst_fwd_o  = dst_fwd_r;
  assign dst_back_o = dst_back_r;

  // ****************************************
  // flags
  // ****************************************
  // periodic flag ignores its enable
  assign cev = {tap_rise, al_hit, upd};
  assign cen = {mode_r[`RTCR_B_PIE], mode_r[`RTCR_B_AIE],
                mode_r[`RTCR_B_UIE]};

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      c_rd_q <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      c_rd_q <= c_rd;
      rd_q   <= bus_i.rd;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_flag
    // events during a read wait in pending
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cflag_r[i] <= 1'b0;
        cpend_r[i] <= 1'b0;
      end else if (c_end) begin
        // read end clears, new events win
        cflag_r[i] <= cpend_r[i] || cev[i];
        cpend_r[i] <= 1'b0;
      end else if (c_rd) begin
        cpend_r[i] <= cpend_r[i] || cev[i];
      end else begin
        cflag_r[i] <= cflag_r[i] || cev[i];
      end
    end

    // extended flags cleared by writing zero only
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
        xflag_r[i] <= 1'b0;
      end else if (xwr) begin
        xflag_r[i] <= (xflag_r[i] && bus_i.wdata[i+1]) || ext_ev_i[i];
      end else begin
        xflag_r[i] <= xflag_r[i] || ext_ev_i[i];
      end
    end
  end

  // six pairs combine onto the pin
  assign combined_irq_flag      = |(cflag_r & cen) || |(xflag_r & xen_r[3:1]);
  assign irq_o     = 1'b0;
  assign irq_oen_o = !combined_irq_flag;

  // ****************************************
  // read path
  // ****************************************
  // unused bits read zero
  always_comb begin
    rd_mux = 8'h00;
    case (bus_i.addr)
      `RTCR_OFS_RATE:   rd_mux = {uip_r, osc_ctrl_r, rate_sel_r};
      `RTCR_OFS_MODE:   rd_mux = mode_r;
      `RTCR_OFS_FLAG:   rd_mux = {combined_irq_flag, cflag_r, 4'h0};
      `RTCR_OFS_SUPPLY: rd_mux = {bat_ok_i || aux_ok_i, 7'h00};
      `RTCR_OFS_XFLAG:  rd_mux = bank_sel_o ? {4'h0, xflag_r, 1'b0} : 8'h00;
      `RTCR_OFS_XEN:    rd_mux = bank_sel_o ? {4'h0, xen_r} : 8'h00;
      default:          rd_mux = 8'h00;
    endcase
  end

  // data caught at read start and held for the whole strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
    end else if (bus_i.rd && !rd_q) begin
      rdata_r <= rd_mux;
    end
  end
  assign bus_rdata_o = rdata_r;

  // ****************************************
  // square wave
  // ****************************************
  // fast enable overrides the selector
  // held low with both enables clear
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sq_r <= 1'b0;
    end else begin
      sq_r <= fast ? ph_r : (mode_r[`RTCR_B_SQUARE_OUT_ENABLE] && tap_lvl);
    end
  end
  assign square_wave_out_o = sq_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  logic [4:0] uip_tk_r;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uip_tk_r <= 5'h00;
    end else if (!uip_r) begin
      uip_tk_r <= 5'h00;
    end else if (tick && uip_tk_r != 5'h1F) begin
      uip_tk_r <= uip_tk_r + 5'h01;
    end
  end

  chk_uip_lead_time: assert property (
    xfer_r |-> uip_tk_r >= 5'(`RTCR_UIP_LEAD_TK))
    else $error("transfer without full pending lead");
  chk_freeze_clears_uip: assert property (
    wr_b && bus_i.wdata[`RTCR_B_SET] |=> !uip_r ##1 !xfer_r)
    else $error("freeze write left pending or transfer");
  chk_freeze_no_xfer: assert property (
    mode_r[`RTCR_B_SET] && $past(mode_r[`RTCR_B_SET]) |-> !xfer_r)
    else $error("transfer while frozen");
  chk_hold_clears_div: assert property (
    !run |=> div_r == 15'h0000)
    else $error("divider not cleared while held");
  chk_bank_write: assert property (
    wr_a |=> bank_sel_o == $past(bus_i.wdata[4]))
    else $error("bank select not taken from write");
  chk_pf_on_tap: assert property (
    tap_rise && !c_rd && !c_end |=> cflag_r[2])
    else $error("periodic flag missed tap edge");
  chk_read_clears: assert property (
    c_end && cev == 3'h0 && cpend_r == 3'h0 |=> cflag_r == 3'h0)
    else $error("flag read did not clear flags");
  chk_stable_in_read: assert property (
    c_rd && c_rd_q |-> $stable(cflag_r))
    else $error("flags moved during read");
  chk_irq_pin_low: assert property (
    |(cflag_r & cen) |-> !irq_oen_o)
    else $error("enabled flag did not drive pin");
  chk_square_low: assert property (
    !fast && !mode_r[`RTCR_B_SQUARE_OUT_ENABLE] |=> !square_wave_out_o)
    else $error("square pin not held low");
  chk_uie_on_freeze: assert property (
    $rose(mode_r[`RTCR_B_SET]) |-> !mode_r[`RTCR_B_UIE])
    else $error("update enable kept on freeze");
  chk_xflag_keep: assert property (
    c_end && !xwr |=> (xflag_r & $past(xflag_r)) == $past(xflag_r))
    else $error("extended flag cleared by read");

  cov_update: cover property (xfer_r ##[1:3] chk_r);
  cov_read_pend: cover property (c_rd && |cev);
  cov_dst_fwd: cover property (dst_fwd_r);

endmodule : rtcr_ctrl
`default_nettype wire

// file: testbench/rtcr_host.sv
// Purpose: host processor model on the byte-wide register port
// Assumes: the bench calls one transfer at a time
// Notes:   idle address and data are scrambled so nothing leans on them
`timescale 1ns/100ps
`default_nettype none

module rtcr_host (
  input  wire logic              clk_sys_i,
  input  wire logic [7:0]        rdata_i,
  output var rtcr_pkg::rtcr_bus_t bus_o
);
  initial bus_o = '{1'b0, 1'b0, 7'h55, 8'hAA};

  // ****************************************
  // write: one-cycle strobe
  // ****************************************
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #2;
    bus_o = '{1'b1, 1'b0, a, d};
    @(posedge clk_sys_i) #2;
    bus_o = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // ****************************************
  // read: strobe held until data is taken
  // ****************************************
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys_i) #2;
    bus_o = '{1'b0, 1'b1, a, 8'h5A};
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    d = rdata_i;
    #2;
    bus_o = '{1'b0, 1'b0, ~a, 8'hA5};
  endtask : rd
endmodule : rtcr_host
`default_nettype wire

// file: testbench/tb_rtcr_ctrl.sv
// Purpose: self-checking bench of the clock control registers
// Assumes: CLK_HZ 65536, so one crystal tick is two cycles
// Notes:   rate periods come from a small integer model
`timescale 1ns/100ps
`default_nettype none
`include "rtcr_map.svh"

module tb_rtcr_ctrl;
  logic                clk_sys_i, rstn_i, xfer, bank, binf, h24;
  logic                dfwd, dback, square_wave_out, irq, irq_oen, bat, aux;
  logic [7:0]          rdata, v;
  logic [2:0]          ev;
  rtcr_pkg::rtcr_bus_t bus;
  rtcr_pkg::rtcr_hms_t tm, al;
  rtcr_pkg::rtcr_cal_t cal;
  int                  errors, n_compared, cyc, seed, r, e, t0;

  rtcr_ctrl #(.CLK_HZ(65536)) DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .bus_i(bus), .bus_rdata_o(rdata), .time_i(tm), .alarm_i(al),
    .cal_i(cal), .ext_ev_i(ev), .bat_ok_i(bat), .aux_ok_i(aux),
    .xfer_o(xfer), .bank_sel_o(bank), .binary_fmt_o(binf),
    .hour24_o(h24), .dst_fwd_o(dfwd), .dst_back_o(dback),
    .square_wave_out_o(square_wave_out), .irq_o(irq), .irq_oen_o(irq_oen));
  rtcr_host host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .bus_o(bus));

  // ****************************************
  // clock, cycle count and hang guard
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      summarize();
    end
  end

  // ****************************************
  // helpers and model
  // ****************************************
  task automatic check(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check
  task automatic rdc(input string nm, input logic [6:0] a,
                     input logic [7:0] exp);
    host.rd(a, v);
    check(nm, v, exp);
  endtask : rdc
  task automatic rises(input int n, output int cnt);
    logic p;
    cnt = 0;
    p = square_wave_out;
    repeat (n) begin
      @(posedge clk_sys_i) #1;
      if (square_wave_out && !p) cnt++;
      p = square_wave_out;
    end
  endtask : rises
  function automatic int per(input int c);
    if (c == 1 || c == 8) return 256;
    if (c == 2 || c == 9) return 512;
    return 8 << (c - 3);
  endfunction : per
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rstn_i, ev, bat, aux, errors, n_compared, cyc} = '0;
    seed = 32'h8ee7;
    tm = '{8'h05, 8'h10, 8'h20};
    al = '{8'hC0, 8'h10, 8'h20};
    cal = '{8'h04, 8'h02, 3'h3};
    repeat (12) @(posedge clk_sys_i);
    #2 rstn_i = 1'b1;
    rdc("reg a rst", `RTCR_OFS_RATE, 8'h00);
    rdc("reg b rst", `RTCR_OFS_MODE, 8'h08);
    host.wr(`RTCR_OFS_FLAG, 8'hFF);
    rdc("reg c ro", `RTCR_OFS_FLAG, 8'h00);
    rdc("xflag bank0", `RTCR_OFS_XFLAG, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {bat, aux} = i[1:0];
      host.wr(`RTCR_OFS_SUPPLY, 8'hFF);
      rdc("reg d", `RTCR_OFS_SUPPLY, (i != 0) ? 8'h80 : 8'h00);
    end
    host.wr(`RTCR_OFS_RATE, 8'hF0);
    rdc("uip ro", `RTCR_OFS_RATE, 8'h70);
    check("bank", bank, 1'b1);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys_i) #2 ev = 3'b001 << k;
      @(posedge clk_sys_i) #2 ev = 3'b000;
      rdc("xflag set", `RTCR_OFS_XFLAG, 8'h02 << k);
      rdc("xflag kept", `RTCR_OFS_XFLAG, 8'h02 << k);
      host.wr(`RTCR_OFS_XEN, 8'h02 << k);
      check("irq xen", irq_oen, 1'b0);
      rdc("combined_irq_flag xen", `RTCR_OFS_FLAG, 8'h80);
      host.wr(`RTCR_OFS_XFLAG, 8'h00);
      check("irq cleared", irq_oen, 1'b1);
      host.wr(`RTCR_OFS_XEN, 8'h00);
    end
    $display("test ext flags done");
    repeat (4) begin
      r = $random(seed) & 32'h0F;
      host.wr(`RTCR_OFS_MODE, r[7:0]);
      rdc("reg b rw", `RTCR_OFS_MODE, r[7:0]);
      check("binary", binf, r[2]);
      check("hour24", h24, r[1]);
    end
    host.wr(`RTCR_OFS_MODE, 8'h18);
    host.wr(`RTCR_OFS_MODE, 8'h98);
    rdc("set clr uie", `RTCR_OFS_MODE, 8'h88);
    host.wr(`RTCR_OFS_MODE, 8'h08);
    $display("test mode done");
    for (int c = 0; c < 10; c++) begin
      host.wr(`RTCR_OFS_RATE, 8'h30 | c[7:0]);
      rises(1024, r);
      e = (c == 0) ? 0 : 1024 / per(c);
      check("sqw rate", (r + 1 >= e) && (r <= e + 1), 1);
    end
    host.rd(`RTCR_OFS_FLAG, v);
    // waiting over one 512-cycle tap period makes sure a tap edge sets the flag again
    repeat (600) @(posedge clk_sys_i);
    rdc("pf set", `RTCR_OFS_FLAG, 8'h40);
    check("pie off", irq_oen, 1'b1);
    host.wr(`RTCR_OFS_MODE, 8'h40);
    rises(600, r);
    check("sqw low", r, 0);
    check("pie on", irq_oen, 1'b0);
    host.wr(`RTCR_OFS_XEN, 8'h01);
    rises(400, r);
    check("fast sqw", (r >= 199) && (r <= 201), 1);
    rdc("pf fast", `RTCR_OFS_FLAG, 8'hC0);
    host.wr(`RTCR_OFS_XEN, 8'h00);
    $display("test rates done");
    tm = '{8'h01, 8'h59, 8'h59};
    al = '{8'hC0, 8'hC0, 8'hC0};
    host.wr(`RTCR_OFS_RATE, 8'h60);
    host.wr(`RTCR_OFS_MODE, 8'h29);
    host.rd(`RTCR_OFS_FLAG, v);
    host.wr(`RTCR_OFS_RATE, 8'h20);
    t0 = cyc;
    while (cyc - t0 < 32736) @(posedge clk_sys_i);
    rdc("uip low", `RTCR_OFS_RATE, 8'h20);
    while (cyc - t0 < 32760) @(posedge clk_sys_i);
    host.rd(`RTCR_OFS_RATE, v);
    check("uip high", v[7], 1'b1);
    while (xfer !== 1'b1 && cyc - t0 < 33000) @(posedge clk_sys_i) #1;
    check("first upd", (cyc - t0 >= 32764) && (cyc - t0 <= 32772), 1);
    e = 0;
    repeat (4) begin
      @(posedge clk_sys_i) #1;
      e = e | dfwd | dback;
    end
    // 1:59:59 with saving on but no Sunday test passed: no jump
    check("no dst unarmed", e, 0);
    check("alarm irq", irq_oen, 1'b0);
    check("irq level", irq, 1'b0);
    rdc("af uf", `RTCR_OFS_FLAG, 8'hB0);
    rdc("read clr", `RTCR_OFS_FLAG, 8'h00);
    check("irq off", irq_oen, 1'b1);
    $display("test update done");
    summarize();
  end
endmodule : tb_rtcr_ctrl
`default_nettype wire
